// File: bench/punched_tape_reader_control_bench.sv
// Self-checking bench for the reader controller.
`define EXPECT(a, b) begin checked++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t mismatch %h %h", $time, a, b); end end
module punched_tape_reader_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, reg_wr, reg_rd, head_open, host_req, no_tape, bad_sum;
  logic [3:0] reg_addr, sw_buf;
  logic [15:0] reg_wdata, d;
  wire [15:0] reg_rdata_ff;
  wire [3:0] adc_sel_ff, nvm_addr_ff;
  wire adc_start_ff, adc_done, illum_ff, nvm_we_ff, servo_wr_ff, step_pulse_ff, step_dir_ff;
  wire fault_indicator_ff, host_ack_ff, host_ready_ff;
  wire [7:0] adc_data, nvm_wdata_ff, nvm_rdata, host_data_ff;
  wire [8:0] servo_data_ff;
  int miscompares = 0, checked = 0;
  punched_tape_reader_control #(.POLL_CYCLES(16), .LAMP_CYCLES(64), .BLINK_CYCLES(32),
    .STEP_CYCLES(8), .LOAD_CHARS(2)) dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata_ff, .sw_buf, .head_open, .adc_sel_ff, .adc_start_ff, .adc_done,
    .adc_data, .illum_ff, .nvm_addr_ff, .nvm_wdata_ff, .nvm_we_ff, .nvm_rdata, .servo_wr_ff,
    .servo_data_ff, .step_pulse_ff, .step_dir_ff, .fault_indicator_ff, .host_req,
    .host_ack_ff, .host_data_ff, .host_ready_ff);
  tape_far_side m (.clk, .adc_sel_ff, .adc_start_ff, .adc_done, .adc_data, .illum_ff,
    .nvm_addr_ff, .nvm_wdata_ff, .nvm_we_ff, .nvm_rdata, .servo_wr_ff, .servo_data_ff,
    .step_pulse_ff, .step_dir_ff, .no_tape, .bad_sum);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask
  task automatic wait_bit(input logic [3:0] a, input int b, input logic v);
    for (int n = 0; n < 4000; n++) begin
      rd(a);
      if (d[b] === v) return;
    end
    miscompares++;
    $display("ERROR %0t wait expired", $time);
    wrap_up();
  endtask
  // Held across several polls; a press is only seen as a change between polls.
  task automatic press(input int i);
    sw_buf[i] <= 1'b1;
    repeat (40) @(posedge clk);
    sw_buf[i] <= 1'b0;
    repeat (40) @(posedge clk);
  endtask
  task automatic ask;
    @(posedge clk);
    host_req <= 1'b1;
    @(posedge clk);
    host_req <= 1'b0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_boot;
    wait_bit(4'h5, 7, 1'b1);
    `EXPECT(d[6], 1'b0)
    rd(4'h4);
    `EXPECT(d, 16'h0400)
    rd(4'hf);
    `EXPECT(d, 16'h0000)
    repeat (4) @(posedge clk);
    `EXPECT(fault_indicator_ff, 1'b0)
  endtask
  task automatic t_cal;
    no_tape <= 1'b1;
    wr(4'h0, 16'h0008);
    for (int n = 0; n < 2000 && illum_ff !== 1'b0; n++) @(posedge clk);
    `EXPECT(illum_ff, 1'b0)
    for (int n = 0; n < 4000 && m.wcnt < 11; n++) @(posedge clk);
    wait_bit(4'h5, 5, 1'b0);
    for (int i = 0; i < 10; i++) `EXPECT(m.mem[i], 8'h80)
    `EXPECT(m.mem[10], 8'h00)
    `EXPECT(d[7], 1'b1)
    no_tape <= 1'b0;
  endtask
  task automatic t_loop;
    int s;
    press(1);
    rd(4'h5);
    `EXPECT(d[4], 1'b1)
    `EXPECT(d[1], 1'b0)
    ask();
    `EXPECT(host_ack_ff, 1'b0)
    wait_bit(4'h5, 4, 1'b0);
    `EXPECT(m.nz, 0)
    `EXPECT(d[9], m.dirn)
    rd(4'h6);
    `EXPECT(d > 16'd400 && d < 16'd640, 1'b1)
    s = m.steps;
    wr(4'h1, 16'h0003);
    wr(4'h0, 16'h0001);
    repeat (80) @(posedge clk);
    `EXPECT(m.steps - s, 3)
    wait_bit(4'h7, 8, 1'b1);
    ask();
    `EXPECT(host_ack_ff, 1'b1)
    `EXPECT(host_data_ff, 8'ha5)
  endtask
  task automatic t_reel;
    wr(4'h2, 16'h0030);
    wr(4'h3, 16'h0050);
    press(0);
    rd(4'h5);
    `EXPECT(d[1], 1'b1)
    `EXPECT(m.cmd[7:0], 8'h30)
    wait_bit(4'h5, 4, 1'b0);
    wr(4'h0, 16'h0005);
    for (int n = 0; n < 3000 && m.cmd[7:0] !== 8'h50; n++) @(posedge clk);
    `EXPECT(m.cmd[7:0], 8'h50)
    wr(4'h0, 16'h0000);
    repeat (10) @(posedge clk);
    `EXPECT(m.cmd[7:0], 8'h00)
  endtask
  task automatic t_rewind;
    press(2);
    rd(4'h5);
    `EXPECT(d[3], 1'b1)
    `EXPECT(d[0], 1'b0)
    `EXPECT(m.cmd, 9'h1ff)
    press(2);
    press(3);
    `EXPECT(m.cmd, 9'h0ff)
    press(3);
    `EXPECT(m.cmd[7:0], 8'h00)
  endtask
  task automatic t_head;
    wr(4'h0, 16'h0005);
    repeat (20) @(posedge clk);
    head_open <= 1'b1;
    rd(4'h5);
    `EXPECT(d[2:0], 3'b110)
    `EXPECT(d[8], 1'b1)
    repeat (2) @(posedge clk);
    #1;
    `EXPECT(m.cmd[7:0], 8'h00)
    head_open <= 1'b0;
    wr(4'h5, 16'h0100);
    rd(4'h5);
    `EXPECT(d[8], 1'b0)
    wr(4'h0, 16'h0000);
  endtask
  task automatic t_sum;
    int tg;
    tg = 0;
    bad_sum <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (100) @(posedge clk);
    rd(4'h5);
    `EXPECT(d[7:6], 2'b01)
    for (int n = 0; n < 160; n++) begin
      @(posedge clk);
      if (fault_indicator_ff === 1'b1) tg++;
    end
    `EXPECT(tg > 20 && tg < 140, 1'b1)
    bad_sum <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    {reg_wr, reg_rd, head_open, host_req, no_tape, bad_sum} = 6'h00;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    sw_buf = 4'h0;
    repeat (10) @(posedge clk);
    `EXPECT({illum_ff, fault_indicator_ff, step_dir_ff, servo_wr_ff}, 4'he)
    rst <= 1'b0;
    t_boot();
    t_cal();
    t_loop();
    t_reel();
    t_rewind();
    t_head();
    t_sum();
    wrap_up();
  end
endmodule
bind punched_tape_reader_control tape_ctl_sva chk (.clk, .rst, .reg_rd, .reg_rdata_ff,
  .head_open, .host_req, .host_ack_ff, .host_ready_ff, .step_pulse_ff, .servo_wr_ff,
  .servo_data_ff, .adc_start_ff, .adc_done, .adc_sel_ff, .nvm_we_ff, .nvm_addr_ff,
  .fault_indicator_ff);

// File: bench/tape_ctl_sva.sv
// Port-level assertions for the reader controller.
module tape_ctl_sva (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic reg_rd, // read strobe
  input wire logic [15:0] reg_rdata_ff, // read data
  input wire logic head_open, // head switch
  input wire logic host_req, // host request
  input wire logic host_ack_ff, // host answer
  input wire logic host_ready_ff, // ready
  input wire logic step_pulse_ff, // step
  input wire logic servo_wr_ff, // servo write
  input wire logic [8:0] servo_data_ff, // servo command
  input wire logic adc_start_ff, // conversion start
  input wire logic adc_done, // conversion done
  input wire logic [3:0] adc_sel_ff, // channel
  input wire logic nvm_we_ff, // memory write
  input wire logic [3:0] nvm_addr_ff, // memory address
  input wire logic fault_indicator_ff // lamp
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_boot;
    $fell(rst);
  endsequence
  sequence s_wait;
    adc_start_ff ##1 !adc_done;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata_ff == 16'h0000)
    else $error("read data outside its cycle");
  a_boot_lamp: assert property (s_boot |-> fault_indicator_ff[*8])
    else $error("lamp not lit at power-up");
  a_head_halt: assert property (head_open[*3] |-> !host_ready_ff && !step_pulse_ff)
    else $error("motion or ready with head open");
  a_head_servo: assert property (head_open[*3] |-> !(servo_wr_ff && servo_data_ff[7:0] != 8'h00))
    else $error("servo moved with head open");
  a_step_gap: assert property (step_pulse_ff |=> !step_pulse_ff[*7])
    else $error("step pulses too close");
  a_conv_one: assert property (adc_start_ff |=> !adc_start_ff && $stable(adc_sel_ff))
    else $error("start not a single pulse");
  a_conv_chan: assert property (adc_start_ff |-> adc_sel_ff <= 4'h9)
    else $error("channel out of range");
  a_sel_hold: assert property (s_wait |=> $stable(adc_sel_ff))
    else $error("channel moved during conversion");
  a_sum_last: assert property (nvm_we_ff && nvm_addr_ff != 4'ha
    |=> nvm_we_ff && nvm_addr_ff == $past(nvm_addr_ff) + 4'h1)
    else $error("memory write order broken");
  a_host_take: assert property (host_ack_ff |-> $past(host_req) && $past(host_ready_ff))
    else $error("answer without ready request");
endmodule

// File: bench/tape_far_side.sv
// Far-side model: readhead with converter, threshold memory and transport.
module tape_far_side #(
  parameter logic [7:0] PATTERN = 8'ha5
) (
  input wire logic clk, // clock
  input wire logic [3:0] adc_sel_ff, // channel
  input wire logic adc_start_ff, // start
  output logic adc_done, // done
  output logic [7:0] adc_data, // result
  input wire logic illum_ff, // illumination
  input wire logic [3:0] nvm_addr_ff, // address
  input wire logic [7:0] nvm_wdata_ff, // write data
  input wire logic nvm_we_ff, // write
  output logic [7:0] nvm_rdata, // read data
  input wire logic servo_wr_ff, // servo write
  input wire logic [8:0] servo_data_ff, // servo command
  input wire logic step_pulse_ff, // step
  input wire logic step_dir_ff, // step direction
  input wire logic no_tape, // empty head
  input wire logic bad_sum // corrupt checksum
);
  logic [7:0] mem [0:10];
  logic [1:0] p = 2'h0;
  logic [8:0] cmd = 9'h000;
  logic slow = 1'b0;
  logic dirn = 1'b0;
  int steps = 0, wcnt = 0, nz = 0, q = 0, lat = 0;
  wire fwd = cmd[7:0] != 8'h00 ? cmd[8] : step_dir_ff;
  function automatic logic [7:0] level(input logic [3:0] ch);
    logic h;
    h = no_tape | (ch == 4'h8 ? p[1] ^ p[0] : ch == 4'h9 ? p[1] : PATTERN[ch[2:0]]);
    return !illum_ff ? 8'h10 : h ? 8'hf0 : 8'h20;
  endfunction
  initial begin
    for (int i = 0; i < 10; i++) mem[i] = 8'h80;
    mem[10] = 8'h00;
    adc_done = 1'b0;
    adc_data = 8'h00;
    nvm_rdata = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Sixteen steps or 128 reel cycles per quarter sprocket, so that a full
  // channel scan always sees each quadrature state.
  always @(posedge clk) begin
    nvm_rdata <= nvm_addr_ff > 4'ha ? ~nvm_rdata : nvm_addr_ff == 4'ha && bad_sum ?
      ~mem[10] : mem[nvm_addr_ff];
    if (nvm_we_ff) begin
      mem[nvm_addr_ff] <= nvm_wdata_ff;
      wcnt <= wcnt + 1;
    end
    if (servo_wr_ff) cmd <= servo_data_ff;
    if (servo_wr_ff && servo_data_ff[7:0] != 8'h00) nz <= nz + 1;
    if (step_pulse_ff) steps <= steps + 1;
    if (q >= 128) begin
      q <= 0;
      p <= fwd ? p + 2'h1 : p - 2'h1;
      dirn <= fwd;
    end else if (step_pulse_ff || cmd[7:0] != 8'h00) q <= q + (step_pulse_ff ? 8 : 1);
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (adc_start_ff) begin
      lat <= slow ? 4 : 1;
      slow <= ~slow;
    end else if (lat == 1) begin
      adc_done <= 1'b1;
      adc_data <= level(adc_sel_ff);
      lat <= 0;
    end else if (lat > 1) lat <= lat - 1;
  end
endmodule

// File: common/tape_ctl_consts.vh
// Constants for the punched-tape reader controller.
// Behaviour
// - Stepper only for loop or strip tape
// - Stepper runs in blocks or continuously
// - Reel mode writes velocity command to servo
// - Revise servo command once speed reaches target
// - Head open: flag, halt motion, not ready
// - Eight data channels plus two sprocket channels
// - Sprockets quadrature: sample timing and speed
// - All channels multiplexed into one converter
// - Load up selects reels, down stepper
// - Rewind switch accepted right or left
// - Fault lamp at power-up, then on faults
// - Panel switches polled periodically, not edges
// - Calibrate dark then lit, store thresholds
// - Reload thresholds after every power-up
// - Checksum in last location, verified on read
// - Checksum mismatch rejects thresholds, blinks lamp
// - Not ready, no reading during rewind
// - Host requests ignored during panel load
`ifndef TAPE_CTL_CONSTS_VH
`define TAPE_CTL_CONSTS_VH
`define NUM_CH 10
`define CH_SPR_A 8
`define CH_SPR_B 9
`define REG_CTRL 4'h0
`define REG_STEPS 4'h1
`define REG_ACCEL 4'h2
`define REG_CRUISE 4'h3
`define REG_TARGET 4'h4
`define REG_STATUS 4'h5
`define REG_SPEED 4'h6
`define REG_DATA 4'h7
`define CTRL_RUN 0
`define CTRL_DIR 1
`define CTRL_CONT 2
`define CTRL_CAL 3
`define STAT_HEVT 8
`define TARGET_RST 16'h0400
`define REWIND_CMD 8'hff
`define CLK_MHZ 250
`define POLL_TIME_US 1000
`define LAMP_TIME_US 500000
`define BLINK_TIME_US 250000
`define STEP_TIME_US 2500
`define LOAD_CHARS 16
`endif

// File: verilog/punched_tape_reader_control.v
// Punched-tape reader controller: transport, sensing, calibration and panel.
//
// Design decisions made here: the strobed register port and the placing of the registers.
`include "tape_ctl_consts.vh"
module punched_tape_reader_control #(
  parameter POLL_CYCLES = `POLL_TIME_US * `CLK_MHZ,
  parameter LAMP_CYCLES = `LAMP_TIME_US * `CLK_MHZ,
  parameter BLINK_CYCLES = `BLINK_TIME_US * `CLK_MHZ,
  parameter STEP_CYCLES = `STEP_TIME_US * `CLK_MHZ,
  parameter LOAD_CHARS = `LOAD_CHARS
) (
  input wire clk, // 250 MHz system clock
  input wire rst, // async reset, active high
  input wire [3:0] reg_addr, // register address
  input wire [15:0] reg_wdata, // register write data
  input wire reg_wr, // write strobe
  input wire reg_rd, // read strobe
  output reg [15:0] reg_rdata_ff, // read data, cycle after strobe
  input wire [3:0] sw_buf, // buffered switches: load up, load down, rew right, rew left
  input wire head_open, // head-open switch, high when open
  output reg [3:0] adc_sel_ff, // channel multiplexer select
  output reg adc_start_ff, // converter start pulse
  input wire adc_done, // converter result valid pulse
  input wire [7:0] adc_data, // converter result
  output reg illum_ff, // readhead illumination on
  output reg [3:0] nvm_addr_ff, // non-volatile memory address
  output reg [7:0] nvm_wdata_ff, // non-volatile write data
  output reg nvm_we_ff, // non-volatile write enable pulse
  input wire [7:0] nvm_rdata, // read data, cycle after address
  output reg servo_wr_ff, // servo bus write pulse
  output reg [8:0] servo_data_ff, // servo command: dir and velocity
  output reg step_pulse_ff, // stepper step pulse
  output reg step_dir_ff, // stepper direction
  output reg fault_indicator_ff, // fault lamp
  input wire host_req, // host character request pulse
  output reg host_ack_ff, // host answer pulse
  output reg [7:0] host_data_ff, // character to host
  output reg host_ready_ff // ready to host
);

localparam ST_BOOT = 3'h0;
localparam ST_READ = 3'h1;
localparam ST_RUN = 3'h2;
localparam ST_CALD = 3'h3;
localparam ST_CALL = 3'h4;
localparam ST_CALW = 3'h5;

reg [2:0] st_ff;
reg [31:0] tmr_ff;
reg [31:0] poll_ff;
reg [31:0] step_cnt_ff;
reg [7:0] smp [0:`NUM_CH-1];
reg [7:0] thr [0:`NUM_CH-1];
reg [3:0] idx_ff;
reg ph_ff;
reg [7:0] sum_ff;
reg [1:0] scans_ff;
reg sc_ph_ff;
reg scan_done_ff;
reg thr_valid_ff;
reg csum_fail_ff;
reg [3:0] sw_ff;
reg head_ff;
reg head_evt_ff;
reg reel_ff;
reg loading_ff;
reg [7:0] load_cnt_ff;
reg rew_ff;
reg rew_dir_ff;
reg spa_ff;
reg [15:0] ivl_cnt_ff;
reg [15:0] ivl_ff;
reg mdir_ff;
reg [7:0] char_ff;
reg new_ff;
reg [3:0] ctrl_ff;
reg [15:0] steps_ff;
reg [15:0] steps_left_ff;
reg [7:0] accel_ff;
reg [7:0] cruise_ff;
reg [15:0] target_ff;
reg blink_ff;
reg [`NUM_CH-1:0] hole;
reg [8:0] nxt_cmd;
reg [15:0] nxt_rdata;
integer i;

wire run_st = (st_ff == ST_RUN);
wire rd_en = run_st & thr_valid_ff & ~head_ff & ~rew_ff;
wire ready = rd_en & ~loading_ff;
wire moving = run_st & ~head_ff & (loading_ff | rew_ff | ctrl_ff[`CTRL_RUN]);
wire poll_tick = (poll_ff == POLL_CYCLES - 1);
wire step_tick = (step_cnt_ff == STEP_CYCLES - 1);
wire [3:0] press = sw_buf & ~sw_ff;
wire spa = hole[`CH_SPR_A];
wire spb = hole[`CH_SPR_B];
wire spa_rise = spa & ~spa_ff;
wire at_speed = (ivl_ff != 16'h0000) && (ivl_ff <= target_ff);
wire cont = loading_ff | rew_ff | ctrl_ff[`CTRL_CONT];
wire wr_ctrl = reg_wr && (reg_addr == `REG_CTRL);
wire cal_req = wr_ctrl & reg_wdata[`CTRL_CAL];

// Classification compares each sample against its own stored trip point.
always @* begin
  for (i = 0; i < `NUM_CH; i = i + 1) begin
    hole[i] = (smp[i] >= thr[i]);
  end
end

////////////////////////////////////////////////////////////////////////////
// Converter scan over all ten channels through the single shared path.

always @(posedge clk or posedge rst) begin
  if (rst) begin
    adc_sel_ff <= 4'h0;
    adc_start_ff <= 1'b0;
    sc_ph_ff <= 1'b0;
    scan_done_ff <= 1'b0;
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      smp[i] <= 8'h00;
    end
  end else begin
    adc_start_ff <= ~sc_ph_ff;
    scan_done_ff <= 1'b0;
    if (~sc_ph_ff) begin
      sc_ph_ff <= 1'b1;
    end else if (adc_done) begin
      smp[adc_sel_ff] <= adc_data;
      sc_ph_ff <= 1'b0;
      if (adc_sel_ff == `NUM_CH - 1) begin
        adc_sel_ff <= 4'h0;
        scan_done_ff <= 1'b1;
      end else begin
        adc_sel_ff <= adc_sel_ff + 4'h1;
      end
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Power-up, threshold reload and calibration sequencer.

always @(posedge clk or posedge rst) begin
  if (rst) begin
    st_ff <= ST_BOOT;
    tmr_ff <= 32'h0;
    idx_ff <= 4'h0;
    ph_ff <= 1'b0;
    sum_ff <= 8'h00;
    scans_ff <= 2'h0;
    thr_valid_ff <= 1'b0;
    csum_fail_ff <= 1'b0;
    illum_ff <= 1'b1;
    nvm_addr_ff <= 4'h0;
    nvm_wdata_ff <= 8'h00;
    nvm_we_ff <= 1'b0;
    blink_ff <= 1'b0;
    fault_indicator_ff <= 1'b1;
    for (i = 0; i < `NUM_CH; i = i + 1) begin
      thr[i] <= 8'h00;
    end
  end else begin
    nvm_we_ff <= 1'b0;
    tmr_ff <= tmr_ff + 32'h1;
    if ((tmr_ff >= BLINK_CYCLES - 1) && (st_ff == ST_RUN)) begin
      tmr_ff <= 32'h0;
      blink_ff <= ~blink_ff;
    end
    case (st_ff)
      ST_BOOT: begin
        // Strap is caught at the end of the lamp period, well after reset release.
        if (tmr_ff >= LAMP_CYCLES - 1) begin
          tmr_ff <= 32'h0;
          idx_ff <= 4'h0;
          ph_ff <= 1'b0;
          sum_ff <= 8'h00;
          scans_ff <= 2'h0;
          nvm_addr_ff <= 4'h0;
          if (sw_buf[1] & sw_buf[2]) begin
            st_ff <= ST_CALD;
            illum_ff <= 1'b0;
          end else begin
            st_ff <= ST_READ;
          end
        end
      end
      ST_READ: begin
        nvm_addr_ff <= idx_ff;
        ph_ff <= ~ph_ff;
        if (ph_ff) begin
          if (idx_ff == `NUM_CH) begin
            thr_valid_ff <= (nvm_rdata == sum_ff);
            csum_fail_ff <= (nvm_rdata != sum_ff);
            st_ff <= ST_RUN;
          end else begin
            thr[idx_ff] <= nvm_rdata;
            sum_ff <= sum_ff + nvm_rdata;
            idx_ff <= idx_ff + 4'h1;
            nvm_addr_ff <= idx_ff + 4'h1;
          end
        end
      end
      ST_RUN: begin
        if (cal_req & ~head_ff) begin
          st_ff <= ST_CALD;
          illum_ff <= 1'b0;
          thr_valid_ff <= 1'b0;
          scans_ff <= 2'h0;
        end
      end
      ST_CALD, ST_CALL: begin
        // The first scan after a lamp change may mix old samples, so take the second.
        if (scan_done_ff) begin
          scans_ff <= scans_ff + 2'h1;
          if (scans_ff == 2'h1) begin
            scans_ff <= 2'h0;
            for (i = 0; i < `NUM_CH; i = i + 1) begin
              if (st_ff == ST_CALD) begin
                thr[i] <= smp[i];
              end else begin
                thr[i] <= thr[i][7:1] + smp[i][7:1] + {7'h00, thr[i][0] & smp[i][0]};
              end
            end
            illum_ff <= 1'b1;
            idx_ff <= 4'h0;
            sum_ff <= 8'h00;
            st_ff <= (st_ff == ST_CALD) ? ST_CALL : ST_CALW;
          end
        end
      end
      ST_CALW: begin
        nvm_we_ff <= 1'b1;
        nvm_addr_ff <= idx_ff;
        if (idx_ff == `NUM_CH) begin
          nvm_wdata_ff <= sum_ff;
          idx_ff <= 4'h0;
          ph_ff <= 1'b0;
          // Pass through the lamp-end step so the reload address is back at zero in time.
          tmr_ff <= LAMP_CYCLES - 1;
          st_ff <= ST_BOOT;
        end else begin
          nvm_wdata_ff <= thr[idx_ff];
          sum_ff <= sum_ff + thr[idx_ff];
          idx_ff <= idx_ff + 4'h1;
        end
        sum_ff <= (idx_ff == `NUM_CH) ? 8'h00 : sum_ff + thr[idx_ff];
      end
      default: begin
        st_ff <= ST_BOOT;
      end
    endcase
    if (st_ff == ST_RUN) begin
      fault_indicator_ff <= csum_fail_ff & blink_ff;
    end else begin
      fault_indicator_ff <= 1'b1;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Panel polling, head switch, load and rewind sequences.

always @(posedge clk or posedge rst) begin
  if (rst) begin
    poll_ff <= 32'h0;
    sw_ff <= 4'h0;
    head_ff <= 1'b1;
    head_evt_ff <= 1'b0;
    reel_ff <= 1'b0;
    loading_ff <= 1'b0;
    load_cnt_ff <= 8'h00;
    rew_ff <= 1'b0;
    rew_dir_ff <= 1'b0;
  end else begin
    head_ff <= head_open;
    poll_ff <= poll_tick ? 32'h0 : poll_ff + 32'h1;
    if (poll_tick) begin
      sw_ff <= sw_buf;
      if (run_st & ~head_ff) begin
        if (press[0] | press[1]) begin
          reel_ff <= press[0];
          loading_ff <= 1'b1;
          load_cnt_ff <= 8'h00;
          rew_ff <= 1'b0;
        end else if (press[2] | press[3]) begin
          rew_ff <= ~rew_ff;
          rew_dir_ff <= press[2];
        end
      end
    end
    if (loading_ff & spa_rise) begin
      load_cnt_ff <= load_cnt_ff + 8'h01;
      if (load_cnt_ff == LOAD_CHARS - 1) begin
        loading_ff <= 1'b0;
      end
    end
    if (head_ff) begin
      loading_ff <= 1'b0;
      rew_ff <= 1'b0;
    end
    // A new head-open event wins over a software clear in the same cycle.
    if (head_open & ~head_ff) begin
      head_evt_ff <= 1'b1;
    end else if (reg_wr && (reg_addr == `REG_STATUS) && reg_wdata[`STAT_HEVT]) begin
      head_evt_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Sprocket timing, character capture and host answers.

always @(posedge clk or posedge rst) begin
  if (rst) begin
    spa_ff <= 1'b0;
    ivl_cnt_ff <= 16'h0000;
    ivl_ff <= 16'h0000;
    mdir_ff <= 1'b0;
    char_ff <= 8'h00;
    new_ff <= 1'b0;
    host_ack_ff <= 1'b0;
    host_data_ff <= 8'h00;
    host_ready_ff <= 1'b0;
  end else begin
    spa_ff <= spa;
    host_ack_ff <= 1'b0;
    host_ready_ff <= ready;
    if (ivl_cnt_ff != 16'hffff) begin
      ivl_cnt_ff <= ivl_cnt_ff + 16'h0001;
    end
    if (spa_rise) begin
      ivl_ff <= ivl_cnt_ff;
      ivl_cnt_ff <= 16'h0000;
      mdir_ff <= ~spb;
    end
    if (spa_rise & rd_en) begin
      char_ff <= hole[7:0];
      new_ff <= 1'b1;
    end else if (host_req & ready & host_ready_ff & new_ff) begin
      host_ack_ff <= 1'b1;
      host_data_ff <= char_ff;
      new_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Transport: stepper for loop tape, servo command for reels.

always @* begin
  if (~reel_ff | ~moving) begin
    nxt_cmd = 9'h000;
  end else if (rew_ff) begin
    nxt_cmd = {rew_dir_ff, `REWIND_CMD};
  end else if (at_speed & ~loading_ff) begin
    nxt_cmd = {ctrl_ff[`CTRL_DIR], cruise_ff};
  end else begin
    nxt_cmd = {loading_ff | ctrl_ff[`CTRL_DIR], accel_ff};
  end
end

always @(posedge clk or posedge rst) begin
  if (rst) begin
    step_cnt_ff <= 32'h0;
    step_pulse_ff <= 1'b0;
    step_dir_ff <= 1'b1;
    steps_left_ff <= 16'h0000;
    servo_wr_ff <= 1'b0;
    servo_data_ff <= 9'h000;
  end else begin
    step_cnt_ff <= step_tick ? 32'h0 : step_cnt_ff + 32'h1;
    step_pulse_ff <= 1'b0;
    step_dir_ff <= rew_ff ? rew_dir_ff : (loading_ff | ctrl_ff[`CTRL_DIR]);
    if (wr_ctrl & reg_wdata[`CTRL_RUN]) begin
      steps_left_ff <= steps_ff;
    end else if (step_tick & moving & ~reel_ff) begin
      if (cont) begin
        step_pulse_ff <= 1'b1;
      end else if (steps_left_ff != 16'h0000) begin
        step_pulse_ff <= 1'b1;
        steps_left_ff <= steps_left_ff - 16'h0001;
      end
    end
    servo_wr_ff <= 1'b0;
    if (nxt_cmd != servo_data_ff) begin
      servo_wr_ff <= 1'b1;
      servo_data_ff <= nxt_cmd;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// Register port.

always @* begin
  case (reg_addr)
    `REG_CTRL: nxt_rdata = {12'h000, ctrl_ff};
    `REG_STEPS: nxt_rdata = steps_ff;
    `REG_ACCEL: nxt_rdata = {8'h00, accel_ff};
    `REG_CRUISE: nxt_rdata = {8'h00, cruise_ff};
    `REG_TARGET: nxt_rdata = target_ff;
    `REG_STATUS: nxt_rdata = {6'h00, mdir_ff, head_evt_ff, thr_valid_ff, csum_fail_ff,
                              ~run_st, loading_ff, rew_ff, head_ff, reel_ff, ready};
    `REG_SPEED: nxt_rdata = ivl_ff;
    `REG_DATA: nxt_rdata = {7'h00, new_ff, char_ff};
    default: nxt_rdata = 16'h0000;
  endcase
end

always @(posedge clk or posedge rst) begin
  if (rst) begin
    reg_rdata_ff <= 16'h0000;
    ctrl_ff <= 4'h0;
    steps_ff <= 16'h0000;
    accel_ff <= 8'h00;
    cruise_ff <= 8'h00;
    target_ff <= `TARGET_RST;
  end else begin
    reg_rdata_ff <= reg_rd ? nxt_rdata : 16'h0000;
    if (reg_wr) begin
      case (reg_addr)
        `REG_CTRL: ctrl_ff <= {1'b0, reg_wdata[2:0]};
        `REG_STEPS: steps_ff <= reg_wdata;
        `REG_ACCEL: accel_ff <= reg_wdata[7:0];
        `REG_CRUISE: cruise_ff <= reg_wdata[7:0];
        `REG_TARGET: target_ff <= reg_wdata;
        default: ctrl_ff <= ctrl_ff;
      endcase
    end
  end
end

endmodule
